// [scb_config_port.sv]
// Serial configuration port and register bank of a dual converter
//
// Function
// - Three-wire or four-wire serial port, chip select
// - Chip-select frame carries two to five bytes
// - Direction bit: zero writes, one reads
// - Two count bits give one to four bytes
// - Five address bits select first register
// - Following bytes go to next lower address
// - Global bit seven selects three-wire port
// - Soft reset restores all but global register
// - Chip power-down leaves serial port working
// - Bandgap power-down switches references off
// - Oscillator off clears its phase accumulator
// - Low-power oscillator uses five top bits
// - Three-bit field selects sideband modulation
// - Two-bit field shifts sampling clock phase
// - Frequency word from four bytes, low first
// - Phase word from two bytes, low first
`timescale 1ns/100ps

module scb_config_port
	import scb_pkg::*;
(
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	input  wire logic                i_clk_en,
	input  wire logic                i_reset_pin_n,
	input  wire logic                i_link_clk,
	input  wire logic                i_chip_select_low_pin_n,
	input  wire logic                i_serial_data_in,
	output logic                     o_serial_data_out,
	output logic                     o_serial_data_oe,
	output logic                     o_serial_out_pin,
	output logic                     o_serial_out_pin_oe,
	output logic                     o_three_wire_select,
	output logic                     o_latch_falling_edge,
	output logic                     o_interleaved_mode,
	output logic                     o_twos_complement,
	output logic                     o_chip_power_down,
	output logic                     o_core_enable,
	output logic                     o_bandgap_power_down,
	output logic                     o_osc_enable,
	output logic                     o_osc_phase_clear,
	output logic                     o_low_power_osc_select,
	output logic                     o_inv_sinc_enable,
	output logic [2:0]               o_modulation,
	output logic [1:0]               o_interpolation,
	output logic                     o_pll_power_down,
	output logic                     o_pll_div_power_down,
	output logic [1:0]               o_pll_divider,
	output logic [1:0]               o_sample_clock_phase,
	output logic                     o_sample_clock_invert,
	output logic [31:0]              o_osc_frequency_word,
	output logic [15:0]              o_osc_phase_word,
	output logic [NUM_CHAN-1:0]      o_chan_power_down,
	output logic [NUM_CHAN-1:0]      o_chan_sleep,
	output logic [NUM_CHAN-1:0][3:0] o_chan_gain_coarse,
	output logic [NUM_CHAN-1:0][5:0] o_chan_gain_fine,
	output logic [NUM_CHAN-1:0][8:0] o_chan_offset,
	output logic [NUM_CHAN-1:0][9:0] o_aux_level,
	output logic [NUM_CHAN-1:0]      o_aux_power_down,
	output logic                     o_osc_minus_3db,
	output logic                     o_noise_shaper
);

	// ---------------------------------------------------------------
	// State types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] regs;
		logic                     tog_seen;
		logic                     tog_s2;
		logic                     tog_s1;
		logic                     rstn_s2;
		logic                     rstn_s1;
	} scb_sys_t;

	typedef struct packed {
		logic [2:0]        bit_cnt;
		logic [6:0]        shift;
		logic              in_data;
		logic              is_read;
		logic [2:0]        remaining;
		logic [ADDR_W-1:0] addr;
		logic              done;
	} scb_frame_t;

	typedef struct packed {
		logic [ADDR_W-1:0] wr_addr;
		logic [7:0]        wr_data;
		logic              wr_toggle;
	} scb_hold_t;

	typedef struct packed {
		logic drive;
		logic out_bit;
	} scb_out_t;

	localparam scb_frame_t FRAME_IDLE = '0;
	localparam scb_hold_t  HOLD_IDLE  = '0;
	localparam scb_out_t   OUT_IDLE   = '0;

	scb_sys_t   sys;
	scb_sys_t   next_sys;
	scb_frame_t frm;
	scb_frame_t next_frm;
	scb_hold_t  hold;
	scb_hold_t  next_hold;
	scb_out_t   outq;
	scb_out_t   next_outq;
	logic [7:0] rx_byte;
	logic       rx_write;
	logic       three_wire;

	// Config bits read across domains are only quasi-static: they move
	// only on writes and resets, and a frame never writes while it reads them.
	assign three_wire = sys.regs[ADDR_GLOBAL_CONTROL][GC_THREE_WIRE];

	// ---------------------------------------------------------------
	// Link domain: frame decode on the rising serial clock edge
	// ---------------------------------------------------------------
	always_comb begin
		next_frm = frm;
		rx_byte  = {frm.shift, i_serial_data_in};
		rx_write = 1'b0;
		if (!frm.done) begin
			next_frm.shift   = rx_byte[6:0];
			next_frm.bit_cnt = frm.bit_cnt + 3'h1;
			if (frm.bit_cnt == LAST_BIT) begin
				if (!frm.in_data) begin
					next_frm.in_data   = 1'b1;
					next_frm.is_read   = rx_byte[INS_DIR_BIT];
					next_frm.remaining = {1'b0, rx_byte[INS_CNT_LSB +: 2]} + 3'h1;
					next_frm.addr      = rx_byte[ADDR_W-1:0];
				end else begin
					rx_write           = !frm.is_read;
					next_frm.addr      = frm.addr - 5'h01;
					next_frm.remaining = frm.remaining - 3'h1;
					next_frm.done      = (frm.remaining == 3'h1);
				end
			end
		end
	end

	// Chip select high clears the frame, so a cut byte is never used
	always_ff @(posedge i_link_clk or posedge i_chip_select_low_pin_n) begin
		if (i_chip_select_low_pin_n) begin
			frm <= FRAME_IDLE;
		end else begin
			frm <= next_frm;
		end
	end

	// ---------------------------------------------------------------
	// Link domain: completed write bytes held for the system side
	// ---------------------------------------------------------------
	always_comb begin
		next_hold = hold;
		if (rx_write) begin
			next_hold.wr_addr   = frm.addr;
			next_hold.wr_data   = rx_byte;
			next_hold.wr_toggle = !hold.wr_toggle;
		end
	end

	// Held data stays put for a whole byte time, far longer than the
	// toggle takes to cross, so the system side samples it stable.
	always_ff @(posedge i_link_clk or negedge i_reset_pin_n) begin
		if (!i_reset_pin_n) begin
			hold <= HOLD_IDLE;
		end else begin
			hold <= next_hold;
		end
	end

	// ---------------------------------------------------------------
	// Link domain: read data launched on the falling edge
	// ---------------------------------------------------------------
	always_comb begin
		next_outq       = outq;
		next_outq.drive = frm.in_data && frm.is_read && !frm.done;
		next_outq.out_bit = sys.regs[frm.addr][LAST_BIT - frm.bit_cnt];
	end

	always_ff @(negedge i_link_clk or posedge i_chip_select_low_pin_n) begin
		if (i_chip_select_low_pin_n) begin
			outq <= OUT_IDLE;
		end else begin
			outq <= next_outq;
		end
	end

	// Pin steering by port arrangement
	assign o_serial_data_out   = outq.out_bit;
	assign o_serial_out_pin    = outq.out_bit;
	assign o_serial_data_oe    = outq.drive && three_wire;
	assign o_serial_out_pin_oe = outq.drive && !three_wire;

	// ---------------------------------------------------------------
	// System domain: crossing and register file
	// ---------------------------------------------------------------
	always_comb begin
		next_sys         = sys;
		next_sys.tog_s1  = hold.wr_toggle;
		next_sys.tog_s2  = sys.tog_s1;
		next_sys.rstn_s1 = i_reset_pin_n;
		next_sys.rstn_s2 = sys.rstn_s1;
		if (i_rst || !sys.rstn_s2) begin
			next_sys.tog_seen = sys.tog_s2;
			for (int i = 0; i < NUM_REGS; i++) begin
				next_sys.regs[i] = reg_default(5'(i));
			end
		end else if (sys.tog_s2 != sys.tog_seen) begin
			next_sys.tog_seen = sys.tog_s2;
			if (hold.wr_addr == ADDR_GLOBAL_CONTROL
				&& hold.wr_data[GC_SOFT_RESET]) begin
				for (int i = 1; i < NUM_REGS; i++) begin
					next_sys.regs[i] = reg_default(5'(i));
				end
			end
			next_sys.regs[hold.wr_addr] = hold.wr_data
				& reg_mask(hold.wr_addr);
		end
	end

	// i_rst overrides the clock enable so a frozen block still resets
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_clk_en) begin
			sys <= next_sys;
		end
	end

	// ---------------------------------------------------------------
	// Global, transmit and clocking controls
	// ---------------------------------------------------------------
	assign o_three_wire_select  = three_wire;
	assign o_latch_falling_edge =
		sys.regs[ADDR_GLOBAL_CONTROL][GC_LATCH_FALL];
	assign o_interleaved_mode   =
		sys.regs[ADDR_GLOBAL_CONTROL][GC_INTERLEAVE];
	assign o_twos_complement    =
		sys.regs[ADDR_GLOBAL_CONTROL][GC_TWOS_COMP];
	assign o_chip_power_down    =
		sys.regs[ADDR_GLOBAL_CONTROL][GC_CHIP_PD];
	// Serial port and registers never depend on this enable
	assign o_core_enable        = !o_chip_power_down;
	assign o_bandgap_power_down =
		sys.regs[ADDR_GLOBAL_CONTROL][GC_BANDGAP_PD];

	assign o_osc_enable = sys.regs[ADDR_TRANSMIT_CONFIG][TX_OSC_EN];
	// Accumulator held at zero degrees while off or powered down
	assign o_osc_phase_clear      = !o_osc_enable || o_chip_power_down;
	assign o_low_power_osc_select =
		sys.regs[ADDR_TRANSMIT_CONFIG][TX_LP_OSC];
	assign o_inv_sinc_enable      =
		sys.regs[ADDR_TRANSMIT_CONFIG][TX_INV_SINC];
	assign o_modulation           =
		sys.regs[ADDR_TRANSMIT_CONFIG][TX_MOD_LSB +: 3];
	assign o_interpolation        =
		sys.regs[ADDR_TRANSMIT_CONFIG][TX_INTERP_LSB +: 2];

	assign o_pll_power_down      = sys.regs[ADDR_PLL_CONFIG][PLL_PD_BIT];
	assign o_pll_div_power_down  =
		sys.regs[ADDR_PLL_CONFIG][PLL_DIV_PD_BIT];
	assign o_pll_divider         = sys.regs[ADDR_PLL_CONFIG][PLL_DIV_LSB +: 2];
	assign o_sample_clock_phase  =
		sys.regs[ADDR_PLL_CONFIG][PLL_PHASE_LSB +: 2];
	assign o_sample_clock_invert = sys.regs[ADDR_PLL_CONFIG][PLL_POL_BIT];

	// ---------------------------------------------------------------
	// Oscillator words
	// ---------------------------------------------------------------
	always_comb begin
		o_osc_frequency_word = {sys.regs[ADDR_OSC_FREQ_BYTE3],
			sys.regs[ADDR_OSC_FREQ_BYTE2],
			sys.regs[ADDR_OSC_FREQ_BYTE1],
			sys.regs[ADDR_OSC_FREQ_BYTE0]};
		o_osc_phase_word = {sys.regs[ADDR_OSC_PHASE_HIGH],
			sys.regs[ADDR_OSC_PHASE_LOW]};
		if (o_low_power_osc_select) begin
			// Coarse steps only: lower bits forced to zero
			o_osc_frequency_word[31-LP_OSC_BITS:0] = '0;
			o_osc_phase_word[15-LP_OSC_BITS:0]     = '0;
		end
	end

	assign o_osc_minus_3db =
		sys.regs[ADDR_OUTPUT_SHAPING][SHP_MINUS_3DB];
	assign o_noise_shaper  = sys.regs[ADDR_OUTPUT_SHAPING][SHP_NOISE];

	// ---------------------------------------------------------------
	// Per-channel gain, offset and auxiliary settings
	// ---------------------------------------------------------------
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		localparam logic [4:0] CFG_BASE = (c == 0)
			? ADDR_CHAN_A_POWER_OFFSET : ADDR_CHAN_B_POWER_OFFSET;
		localparam logic [4:0] AUX_BASE = (c == 0)
			? ADDR_AUX_A_HIGH : ADDR_AUX_B_HIGH;
		logic [7:0] cfg_pwr;
		logic [7:0] cfg_gain;
		logic [7:0] cfg_high;
		logic [7:0] aux_high;
		logic [7:0] aux_low;

		assign cfg_pwr  = sys.regs[CFG_BASE];
		assign cfg_gain = sys.regs[CFG_BASE + 5'h01];
		assign cfg_high = sys.regs[CFG_BASE + 5'h02];
		assign aux_high = sys.regs[AUX_BASE];
		assign aux_low  = sys.regs[AUX_BASE + 5'h01];

		assign o_chan_power_down[c]  = cfg_pwr[CH_PD_BIT];
		assign o_chan_sleep[c]       = cfg_pwr[CH_SLEEP_BIT];
		assign o_chan_gain_coarse[c] = {cfg_high[7:6], cfg_gain[7:6]};
		assign o_chan_gain_fine[c]   = cfg_gain[5:0];
		assign o_chan_offset[c]      = {cfg_high[5:0],
			cfg_pwr[CH_OFS_LSB +: 3]};
		assign o_aux_level[c]        = {aux_high, aux_low[1:0]};
		assign o_aux_power_down[c]   = aux_low[AUX_PD_BIT];
	end

endmodule : scb_config_port

// [scb_config_port_checker.sv]
// Assertion checker for the serial configuration bank
`timescale 1ns/100ps

module scb_config_port_checker (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_reset_pin_n,
	input  wire logic        i_chip_select_low_pin_n,
	input  wire logic        o_serial_data_oe,
	input  wire logic        o_serial_out_pin_oe,
	input  wire logic        o_three_wire_select,
	input  wire logic        o_chip_power_down,
	input  wire logic        o_core_enable,
	input  wire logic        o_osc_enable,
	input  wire logic        o_osc_phase_clear,
	input  wire logic        o_low_power_osc_select,
	input  wire logic [2:0]  o_modulation,
	input  wire logic [31:0] o_osc_frequency_word,
	input  wire logic [15:0] o_osc_phase_word
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	// Idle cycles; long enough that late commits have landed
	logic [3:0] idle_cnt;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !i_reset_pin_n || !i_chip_select_low_pin_n) begin
			idle_cnt <= 4'h0;
		end else if (idle_cnt != 4'hf) begin
			idle_cnt <= idle_cnt + 4'h1;
		end
	end

	// ----------------------------------------------------------
	// Properties
	// ----------------------------------------------------------
	oe_idle_a: assert property (
		i_chip_select_low_pin_n |-> !o_serial_data_oe && !o_serial_out_pin_oe)
		else $error("output enable while deselected");
	pin_three_a: assert property (
		o_serial_out_pin_oe |-> !o_three_wire_select)
		else $error("output pin driven in three-wire form");
	pin_four_a: assert property (
		o_serial_data_oe |-> o_three_wire_select)
		else $error("data pin driven in four-wire form");
	core_off_a: assert property (
		$rose(o_chip_power_down) |-> !o_core_enable && o_osc_phase_clear)
		else $error("power-down did not stop the core");
	phase_clear_a: assert property (
		!o_osc_enable |-> o_osc_phase_clear)
		else $error("oscillator off without phase clear");
	low_power_a: assert property (
		o_low_power_osc_select |-> o_osc_frequency_word[26:0] == 27'h0
		&& o_osc_phase_word[10:0] == 11'h0)
		else $error("low-power words keep low bits");
	pin_reset_a: assert property (
		(!i_reset_pin_n) [*4] |-> o_osc_frequency_word == 32'h2666_6666
		&& o_osc_phase_word == 16'h0000 && o_three_wire_select
		&& o_osc_enable && o_modulation == 3'h1)
		else $error("reset pin did not restore defaults");
	quiet_bank_a: assert property (
		idle_cnt == 4'hf |-> $stable(o_osc_frequency_word)
		&& $stable(o_osc_phase_word) && $stable(o_modulation))
		else $error("register changed outside a frame");
endmodule : scb_config_port_checker

bind scb_config_port scb_config_port_checker scb_config_port_checker_inst (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_pin_n(i_reset_pin_n),
	.i_chip_select_low_pin_n(i_chip_select_low_pin_n),
	.o_serial_data_oe(o_serial_data_oe),
	.o_serial_out_pin_oe(o_serial_out_pin_oe),
	.o_three_wire_select(o_three_wire_select),
	.o_chip_power_down(o_chip_power_down), .o_core_enable(o_core_enable),
	.o_osc_enable(o_osc_enable), .o_osc_phase_clear(o_osc_phase_clear),
	.o_low_power_osc_select(o_low_power_osc_select),
	.o_modulation(o_modulation),
	.o_osc_frequency_word(o_osc_frequency_word),
	.o_osc_phase_word(o_osc_phase_word)
);

// [scb_host_model.sv]
// Host serial master model driving the configuration link
`timescale 1ns/100ps

module scb_host_model (
	output logic      o_link_clk,
	output logic      o_cs_n,
	output logic      o_sdio,
	input  wire logic i_dev_out,
	input  wire logic i_dev_oe,
	input  wire logic i_pin_out,
	input  wire logic i_pin_oe
);
	logic host_bit;

	// Released wire toggles so a stale level never reads as data
	assign o_sdio = i_dev_oe ? i_dev_out : host_bit;

	initial begin
		o_link_clk = 1'b0;
		o_cs_n = 1'b0;
		host_bit = 1'b1;
		// Early rise clears the device's frame flops
		#10 o_cs_n = 1'b1;
	end

	// Clock stands still outside frames; data changes on falling edge
	task automatic xfer(input logic rd, input logic [1:0] cnt,
		input logic [4:0] addr, input logic [31:0] wdata, input int stop,
		output logic [31:0] rdata);
		logic [39:0] sh;
		int          nbits;
		sh = {rd, cnt, addr, wdata};
		nbits = 16 + 8 * int'(cnt);
		if (stop != 0) nbits = stop;
		rdata = '0;
		o_cs_n = 1'b0;
		#80;
		for (int i = 0; i < nbits; i++) begin
			o_link_clk = 1'b0;
			host_bit = (rd && i >= 8) ? ~host_bit : sh[39 - i];
			#80;
			if (i >= 8) rdata = {rdata[30:0], i_pin_oe ? i_pin_out : o_sdio};
			o_link_clk = 1'b1;
			#80;
		end
		rdata = rdata << (40 - nbits);
		o_link_clk = 1'b0;
		#80;
		o_cs_n = 1'b1;
		host_bit = ~host_bit;
		#320;
	endtask : xfer
endmodule : scb_host_model

// [scb_pkg.sv]
// Constants, register map and helpers of the serial configuration bank
package scb_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int          NUM_REGS = 32;
	localparam int          ADDR_W   = 5;
	localparam int          NUM_CHAN = 2;
	localparam logic [2:0]  LAST_BIT = 3'h7;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] ADDR_GLOBAL_CONTROL      = 5'h00;
	localparam logic [4:0] ADDR_TRANSMIT_CONFIG     = 5'h01;
	localparam logic [4:0] ADDR_PLL_CONFIG          = 5'h02;
	localparam logic [4:0] ADDR_OSC_FREQ_BYTE0      = 5'h03;
	localparam logic [4:0] ADDR_OSC_FREQ_BYTE1      = 5'h04;
	localparam logic [4:0] ADDR_OSC_FREQ_BYTE2      = 5'h05;
	localparam logic [4:0] ADDR_OSC_FREQ_BYTE3      = 5'h06;
	localparam logic [4:0] ADDR_OSC_PHASE_LOW       = 5'h07;
	localparam logic [4:0] ADDR_OSC_PHASE_HIGH      = 5'h08;
	localparam logic [4:0] ADDR_CHAN_A_POWER_OFFSET = 5'h09;
	localparam logic [4:0] ADDR_CHAN_A_GAIN_LOW     = 5'h0a;
	localparam logic [4:0] ADDR_CHAN_A_GAIN_OFFSET  = 5'h0b;
	localparam logic [4:0] ADDR_CHAN_B_POWER_OFFSET = 5'h0c;
	localparam logic [4:0] ADDR_CHAN_B_GAIN_LOW     = 5'h0d;
	localparam logic [4:0] ADDR_CHAN_B_GAIN_OFFSET  = 5'h0e;
	localparam logic [4:0] ADDR_OUTPUT_SHAPING      = 5'h0f;
	localparam logic [4:0] ADDR_AUX_A_HIGH          = 5'h1a;
	localparam logic [4:0] ADDR_AUX_A_LOW_POWER     = 5'h1b;
	localparam logic [4:0] ADDR_AUX_B_HIGH          = 5'h1c;
	localparam logic [4:0] ADDR_AUX_B_LOW_POWER     = 5'h1d;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] DEF_GLOBAL_CONTROL  = 8'h80;
	localparam logic [7:0] DEF_TRANSMIT_CONFIG = 8'h87;
	localparam logic [7:0] DEF_PLL_CONFIG      = 8'h10;
	localparam logic [7:0] DEF_OSC_FREQ_LOW    = 8'h66;
	localparam logic [7:0] DEF_OSC_FREQ_TOP    = 8'h26;
	localparam logic [7:0] DEF_CHAN_GAIN_LOW   = 8'h40;
	localparam logic [7:0] DEF_CHAN_GAIN_HIGH  = 8'hc0;
	localparam logic [7:0] DEF_AUX_HIGH        = 8'h80;
	localparam logic [7:0] DEF_ZERO            = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int GC_THREE_WIRE  = 7;
	localparam int GC_SOFT_RESET  = 6;
	localparam int GC_LATCH_FALL  = 5;
	localparam int GC_INTERLEAVE  = 3;
	localparam int GC_TWOS_COMP   = 2;
	localparam int GC_CHIP_PD     = 1;
	localparam int GC_BANDGAP_PD  = 0;
	localparam int TX_OSC_EN      = 7;
	localparam int TX_LP_OSC      = 6;
	localparam int TX_INV_SINC    = 5;
	localparam int TX_MOD_LSB     = 2;
	localparam int TX_INTERP_LSB  = 0;
	localparam int PLL_PD_BIT     = 7;
	localparam int PLL_DIV_PD_BIT = 5;
	localparam int PLL_DIV_LSB    = 3;
	localparam int PLL_PHASE_LSB  = 1;
	localparam int PLL_POL_BIT    = 0;
	localparam int CH_PD_BIT      = 7;
	localparam int CH_SLEEP_BIT   = 6;
	localparam int CH_OFS_LSB     = 3;
	localparam int AUX_PD_BIT     = 7;
	localparam int SHP_MINUS_3DB  = 1;
	localparam int SHP_NOISE      = 0;
	localparam int INS_DIR_BIT    = 7;
	localparam int INS_CNT_LSB    = 5;
	localparam int LP_OSC_BITS    = 5;

	// Reset value of each register, zero where unmapped
	function automatic logic [7:0] reg_default(input logic [4:0] a);
		case (a)
			ADDR_GLOBAL_CONTROL:     reg_default = DEF_GLOBAL_CONTROL;
			ADDR_TRANSMIT_CONFIG:    reg_default = DEF_TRANSMIT_CONFIG;
			ADDR_PLL_CONFIG:         reg_default = DEF_PLL_CONFIG;
			ADDR_OSC_FREQ_BYTE0,
			ADDR_OSC_FREQ_BYTE1,
			ADDR_OSC_FREQ_BYTE2:     reg_default = DEF_OSC_FREQ_LOW;
			ADDR_OSC_FREQ_BYTE3:     reg_default = DEF_OSC_FREQ_TOP;
			ADDR_CHAN_A_GAIN_LOW,
			ADDR_CHAN_B_GAIN_LOW:    reg_default = DEF_CHAN_GAIN_LOW;
			ADDR_CHAN_A_GAIN_OFFSET,
			ADDR_CHAN_B_GAIN_OFFSET: reg_default = DEF_CHAN_GAIN_HIGH;
			ADDR_AUX_A_HIGH,
			ADDR_AUX_B_HIGH:         reg_default = DEF_AUX_HIGH;
			default:                 reg_default = DEF_ZERO;
		endcase
	endfunction : reg_default

	// Storable bits; reserved and unmapped bits read zero
	function automatic logic [7:0] reg_mask(input logic [4:0] a);
		case (a)
			ADDR_GLOBAL_CONTROL:      reg_mask = 8'haf;
			ADDR_PLL_CONFIG:          reg_mask = 8'hbf;
			ADDR_CHAN_A_POWER_OFFSET,
			ADDR_CHAN_B_POWER_OFFSET: reg_mask = 8'hf8;
			ADDR_OUTPUT_SHAPING:      reg_mask = 8'h03;
			ADDR_AUX_A_LOW_POWER,
			ADDR_AUX_B_LOW_POWER:     reg_mask = 8'h83;
			ADDR_TRANSMIT_CONFIG,
			ADDR_OSC_FREQ_BYTE0,
			ADDR_OSC_FREQ_BYTE1,
			ADDR_OSC_FREQ_BYTE2,
			ADDR_OSC_FREQ_BYTE3,
			ADDR_OSC_PHASE_LOW,
			ADDR_OSC_PHASE_HIGH,
			ADDR_CHAN_A_GAIN_LOW,
			ADDR_CHAN_A_GAIN_OFFSET,
			ADDR_CHAN_B_GAIN_LOW,
			ADDR_CHAN_B_GAIN_OFFSET,
			ADDR_AUX_A_HIGH,
			ADDR_AUX_B_HIGH:          reg_mask = 8'hff;
			default:                  reg_mask = 8'h00;
		endcase
	endfunction : reg_mask

endpackage : scb_pkg

// [testbench.sv]
// Self-checking bench for the serial configuration bank
`timescale 1ns/100ps

module testbench;
	logic        i_sys_clk, i_rst, i_reset_pin_n;
	logic        link_clk, cs_n, sdio, doe, dout, poe, pout;
	logic        three_w, cpd, core_en, bgpd, osc_en, phclr;
	logic [2:0]  mod;
	logic [1:0]  scph;
	logic [31:0] fw;
	logic [15:0] pw;
	logic [1:0][8:0] chof;
	logic [7:0]  sh [32];
	int          n_errors, compares;
	int          cycles = 0;

	scb_config_port scb_config_port_inst (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1),
		.i_reset_pin_n(i_reset_pin_n), .i_link_clk(link_clk),
		.i_chip_select_low_pin_n(cs_n), .i_serial_data_in(sdio),
		.o_serial_data_out(dout), .o_serial_data_oe(doe),
		.o_serial_out_pin(pout), .o_serial_out_pin_oe(poe),
		.o_three_wire_select(three_w), .o_latch_falling_edge(),
		.o_interleaved_mode(), .o_twos_complement(),
		.o_chip_power_down(cpd), .o_core_enable(core_en),
		.o_bandgap_power_down(bgpd), .o_osc_enable(osc_en),
		.o_osc_phase_clear(phclr), .o_low_power_osc_select(),
		.o_inv_sinc_enable(), .o_modulation(mod), .o_interpolation(),
		.o_pll_power_down(), .o_pll_div_power_down(), .o_pll_divider(),
		.o_sample_clock_phase(scph), .o_sample_clock_invert(),
		.o_osc_frequency_word(fw), .o_osc_phase_word(pw),
		.o_chan_power_down(), .o_chan_sleep(), .o_chan_gain_coarse(),
		.o_chan_gain_fine(), .o_chan_offset(chof), .o_aux_level(),
		.o_aux_power_down(), .o_osc_minus_3db(), .o_noise_shaper()
	);
	scb_host_model scb_host_model_inst (
		.o_link_clk(link_clk), .o_cs_n(cs_n), .o_sdio(sdio),
		.i_dev_out(dout), .i_dev_oe(doe), .i_pin_out(pout), .i_pin_oe(poe)
	);

	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	// ----------------------------------------------------------
	// Register table and shared tasks
	// ----------------------------------------------------------
	function automatic logic [7:0] dflt(input logic [4:0] a);
		case (a)
			5'h00, 5'h1a, 5'h1c: dflt = 8'h80;
			5'h01:               dflt = 8'h87;
			5'h02:               dflt = 8'h10;
			5'h03, 5'h04, 5'h05: dflt = 8'h66;
			5'h06:               dflt = 8'h26;
			5'h0a, 5'h0d:        dflt = 8'h40;
			5'h0b, 5'h0e:        dflt = 8'hc0;
			default:             dflt = 8'h00;
		endcase
	endfunction : dflt

	// Reserved bits and unmapped places read zero
	function automatic logic [7:0] msk(input logic [4:0] a);
		case (a)
			5'h00:        msk = 8'haf;
			5'h02:        msk = 8'hbf;
			5'h09, 5'h0c: msk = 8'hf8;
			5'h0f:        msk = 8'h03;
			5'h1b, 5'h1d: msk = 8'h83;
			5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
			5'h18, 5'h19, 5'h1e, 5'h1f: msk = 8'h00;
			default:      msk = 8'hff;
		endcase
	endfunction : msk

	task automatic load_defaults(input int first);
		for (int j = first; j < 32; j++) sh[j] = dflt(5'(j));
	endtask : load_defaults

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h",
				$time, what, got, exp);
		end
	endtask : chk

	task automatic chk_out();
		logic [31:0] f;
		logic [15:0] p;
		logic [3:0]  g;
		logic [6:0]  t;
		logic [17:0] ofs;
		f = {sh[6], sh[5], sh[4], sh[3]};
		ofs = {sh[14][5:0], sh[12][5:3], sh[11][5:0], sh[9][5:3]};
		p = {sh[8], sh[7]};
		if (sh[1][6]) begin
			f[26:0] = '0;
			p[10:0] = '0;
		end
		g = {sh[0][7], sh[0][1], ~sh[0][1], sh[0][0]};
		t = {sh[1][7], ~sh[1][7] | sh[0][1], sh[1][4:2], sh[2][2:1]};
		chk(fw, f, "frequency word");
		chk(32'(pw), 32'(p), "phase word");
		chk(32'({three_w, cpd, core_en, bgpd}), 32'(g), "global");
		chk(32'({osc_en, phclr, mod, scph}), 32'(t), "fields");
		chk(32'(chof), 32'(ofs), "channel offset");
	endtask : chk_out

	// Soft reset takes effect in the same commit as the global byte
	task automatic wr(input logic [1:0] cnt, input logic [4:0] a,
		input logic [31:0] d);
		logic [31:0] r;
		logic [4:0]  x;
		logic [7:0]  b;
		scb_host_model_inst.xfer(1'b0, cnt, a, d, 0, r);
		for (int k = 0; k <= int'(cnt); k++) begin
			x = a - 5'(k);
			b = d[31 - 8 * k -: 8];
			sh[x] = b & msk(x);
			if (x == 5'h00 && b[6]) load_defaults(1);
		end
		repeat (8) @(posedge i_sys_clk);
		chk_out();
	endtask : wr

	task automatic rd(input logic [1:0] cnt, input logic [4:0] a);
		logic [31:0] r;
		logic [4:0]  x;
		scb_host_model_inst.xfer(1'b1, cnt, a, 32'h0000_0000, 0, r);
		for (int k = 0; k <= int'(cnt); k++) begin
			x = a - 5'(k);
			chk(32'(r[31 - 8 * k -: 8]), 32'(sh[x]), "read byte");
		end
	endtask : rd

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		logic [31:0] r;
		i_rst = 1'b1;
		i_reset_pin_n = 1'b1;
		n_errors = 0;
		compares = 0;
		load_defaults(0);
		@(posedge i_sys_clk);
		// Pin reset at power-up clears the link-side write toggle
		i_reset_pin_n <= 1'b0;
		repeat (11) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		i_reset_pin_n <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		chk_out();
		for (int a = 3; a < 32; a += 4) begin
			rd(2'b11, 5'(a));
		end
		wr(2'b11, 5'h06, 32'h1234_5678);
		wr(2'b01, 5'h08, 32'habcd_0000);
		wr(2'b10, 5'h0e, 32'h5a3c_9600);
		rd(2'b10, 5'h0e);
		for (int m = 0; m < 5; m++) begin
			wr(2'b00, 5'h01, {3'h4, 3'(m), 2'h1, 24'h00_0000});
		end
		for (int p = 0; p < 3; p++) begin
			wr(2'b00, 5'h02, {5'h02, 2'(p), 1'h1, 24'h00_0000});
		end
		wr(2'b00, 5'h01, 32'h4700_0000);
		wr(2'b00, 5'h00, 32'h0000_0000);
		rd(2'b01, 5'h08);
		wr(2'b00, 5'h00, 32'h8300_0000);
		rd(2'b01, 5'h0e);
		wr(2'b00, 5'h00, 32'hc000_0000);
		rd(2'b11, 5'h08);
		scb_host_model_inst.xfer(1'b0, 2'b00, 5'h07, 32'hff00_0000, 12, r);
		repeat (8) @(posedge i_sys_clk);
		rd(2'b00, 5'h07);
		wr(2'b00, 5'h05, 32'h1100_0000);
		i_reset_pin_n <= 1'b0;
		repeat (5) @(posedge i_sys_clk);
		i_reset_pin_n <= 1'b1;
		load_defaults(0);
		repeat (4) @(posedge i_sys_clk);
		chk_out();
		rd(2'b11, 5'h1d);
		report_and_stop();
	end
endmodule : testbench
